// >>> hdl/tdc_cfg.svh
// Constants for the turbo decoder port shell
`ifndef TDC_CFG_SVH
`define TDC_CFG_SVH
// 0 = 3GPP, 1 = 3GPP2, 2 = CCSDS
`define TDC_STD        0
`define TDC_SOFT_W     6
`define TDC_LEN_W      13
`define TDC_MAX_LEN    5114
`define TDC_ITER_W     4
`define TDC_RATE_W     1
`define TDC_DOUBLE_BUF 1'b1
`define TDC_MEM_LAT    1
`define TDC_AXI_AW     4
`define TDC_REG_CTRL   4'h0
`define TDC_REG_STAT   4'h4
`define TDC_REG_CNT    4'h8
`define TDC_CTRL_CLR   0
`define TDC_CTRL_HOLD  1
`define TDC_RESP_OK    2'b00
`define TDC_RESP_ERR   2'b10
`endif

// >>> hdl/tdc_pkg.sv
// Types shared by the turbo decoder port shell
`include "tdc_cfg.svh"
`default_nettype none
package tdc_pkg;
  typedef enum logic [1:0] {DEC_IDLE, DEC_READ, DEC_FLUSH} tdc_dec_e;
  typedef logic [`TDC_SOFT_W-1:0] tdc_soft_t;
  typedef logic [`TDC_LEN_W-1:0]  tdc_len_t;
  typedef logic [`TDC_ITER_W-1:0] tdc_iter_t;
  typedef logic [`TDC_RATE_W-1:0] tdc_rate_t;
endpackage
`default_nettype wire

// >>> hdl/tdc_top.sv
// Turbo decoder port shell: symbol intake, external memory, hard-decision output
// How it works
// - Iteration input is 4 bits, 1 to 15; that many passes run per block.
// - Block length, iterations and rate load only on the config strobe; fill restarts.
// - Block length bus is 13 to 15 bits, up to 20730.
// - Soft symbol is taken only in cycles with input valid high.
// - Soft symbol is 3 to 6 bits, fixed by configuration.
// - Input ready falls as the last symbol fitting the buffer is taken.
// - Output ready is high while decoded bits wait on the hard output.
// - 3GPP rate bit: 0 is rate 1/3, 1 is rate 1/2.
// - 3GPP2 rate: 0..3 select 1/2, 1/3, 1/4, 1/5.
// - CCSDS rate: 0..3 select 1/2, 1/3, 1/4, 1/6.
// - Asynchronous active-low reset plus a separate synchronous clear.
// - Info, systematic and interleaved parity go to three buffers, own enables.
// - One shared write word and address; the enable picks the buffer.
// - Two read ports, each with read enable and information address.
// - Each read port also drives a parity address; parities return separately.
// - Double buffering adds second return inputs and write enables.
// - Synchronous clear at any time abandons the current block.
// - One bit per acknowledge; output ready drops after the last bit.
// - Input ready falls with one block held, or two with double buffers.
// - Memory read data returns a fixed 1 to 6 cycles after the read.
`include "tdc_cfg.svh"
`default_nettype none
module tdc_top (
  // Clock and resets
  input  wire logic             ref_clk,
  input  wire logic             rst_b,
  input  wire logic             sync_clear,
  // Block configuration
  input  wire tdc_pkg::tdc_len_t  blockLen,
  input  wire tdc_pkg::tdc_iter_t iterCount,
  input  wire tdc_pkg::tdc_rate_t codeRate,
  input  wire logic             blockCfgSet,
  // Symbol input
  input  wire tdc_pkg::tdc_soft_t softIn,
  input  wire logic             inValid,
  output logic                  inReady,
  // Hard-decision output
  output logic                  hardOut,
  output logic                  outReady,
  input  wire logic             outAck,
  // External memory write side
  output tdc_pkg::tdc_soft_t    mem_write_word,
  output tdc_pkg::tdc_len_t     memWriteAddr,
  output logic                  info_we_a,
  output logic                  sys_parity_we_a,
  output logic                  intl_parity_we_a,
  output logic                  info_we_b,
  output logic                  sys_parity_we_b,
  output logic                  intl_parity_we_b,
  // External memory read ports
  output logic                  port_one_read_en,
  output logic                  port_two_read_en,
  output tdc_pkg::tdc_len_t     port_one_info_addr,
  output tdc_pkg::tdc_len_t     port_two_info_addr,
  output tdc_pkg::tdc_len_t     port_one_parity_addr,
  output tdc_pkg::tdc_len_t     port_two_parity_addr,
  input  wire tdc_pkg::tdc_soft_t port_one_info_a,
  input  wire tdc_pkg::tdc_soft_t port_two_info_a,
  input  wire tdc_pkg::tdc_soft_t port_one_sys_parity_a,
  input  wire tdc_pkg::tdc_soft_t port_two_sys_parity_a,
  input  wire tdc_pkg::tdc_soft_t port_one_intl_parity_a,
  input  wire tdc_pkg::tdc_soft_t port_two_intl_parity_a,
  input  wire tdc_pkg::tdc_soft_t port_one_info_b,
  input  wire tdc_pkg::tdc_soft_t port_two_info_b,
  input  wire tdc_pkg::tdc_soft_t port_one_sys_parity_b,
  input  wire tdc_pkg::tdc_soft_t port_two_sys_parity_b,
  input  wire tdc_pkg::tdc_soft_t port_one_intl_parity_b,
  input  wire tdc_pkg::tdc_soft_t port_two_intl_parity_b,
  // AXI4-Lite register slave
  input  wire logic [`TDC_AXI_AW-1:0] s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  input  wire logic [`TDC_AXI_AW-1:0] s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready
);
  import tdc_pkg::*;

  localparam int LAT = `TDC_MEM_LAT;

  // Symbols per decoded bit for the selected standard and rate
  function automatic logic [2:0] symsPerBit(input logic [1:0] r);
    if (`TDC_STD == 0) return r[0] ? 3'd2 : 3'd3;
    if (`TDC_STD == 1) return 3'(r) + 3'd2;
    return (r == 2'd3) ? 3'd6 : 3'(r) + 3'd2;
  endfunction

  logic        clr;
  logic        softClr_r;
  logic        inHold_r;
  tdc_len_t    cfgLen_r;
  tdc_iter_t   cfgIter_r;
  tdc_rate_t   cfgRate_r;
  tdc_len_t    fillIdx_r;
  logic [2:0]  phase_r;
  logic [2:0]  spb;
  logic        take;
  logic        lastSym;
  logic [1:0]  bufFull_r;
  logic [1:0]  fullNxt;
  logic        fillSel_r;
  logic        decSel_r;
  logic        inReady_r;
  logic [5:0]  we_r;
  tdc_soft_t   word_r;
  tdc_len_t    waddr_r;
  tdc_dec_e    state_r;
  tdc_len_t    decLen_r;
  tdc_iter_t   decIter_r;
  tdc_len_t    rdIdx_r;
  tdc_len_t    revIdx_r;
  tdc_iter_t   passCnt_r;
  logic        rdEn_r;
  logic        rdFin_r;
  logic [LAT-1:0] pv_r;
  logic [LAT-1:0] pf_r;
  tdc_len_t    pi_r [LAT];
  logic        retFin;
  tdc_len_t    retIdx;
  logic        decEnd;
  logic [6:0]  llr;
  logic        hardMem [`TDC_MAX_LEN];
  logic        outReady_r;
  logic        hardOut_r;
  tdc_len_t    outIdx_r;
  tdc_len_t    outLen_r;
  logic [15:0] blkCnt_r;
  logic        awRdy_r;
  logic        wRdy_r;
  logic        bValid_r;
  logic [1:0]  bResp_r;
  logic [`TDC_AXI_AW-1:0] awAddr_r;
  logic [31:0] wData_r;
  logic        wStrb0_r;
  logic        wrGo;
  logic        arRdy_r;
  logic        rValid_r;
  logic [1:0]  rResp_r;
  logic [31:0] rData_r;

  assign clr = sync_clear || softClr_r;

  // Configuration capture on the block configuration strobe
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cfgLen_r  <= '0;
      cfgIter_r <= '0;
      cfgRate_r <= '0;
    end else if (blockCfgSet) begin
      cfgLen_r  <= blockLen;
      cfgIter_r <= iterCount;
      cfgRate_r <= codeRate;
    end
  end

  // Symbol intake
  assign spb     = symsPerBit(2'(cfgRate_r));
  assign take    = inValid && inReady_r;
  assign lastSym = take && (phase_r == spb - 3'd1) && (fillIdx_r == cfgLen_r - 1'b1);

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      fillIdx_r <= '0;
      phase_r   <= '0;
    end else if (clr || blockCfgSet) begin
      fillIdx_r <= '0;
      phase_r   <= '0;
    end else if (take) begin
      if (phase_r == spb - 3'd1) begin
        phase_r   <= '0;
        fillIdx_r <= lastSym ? '0 : fillIdx_r + 1'b1;
      end else begin
        phase_r <= phase_r + 3'd1;
      end
    end
  end

  // Shared write word; enable picks info, systematic or interleaved buffer
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      we_r    <= '0;
      word_r  <= '0;
      waddr_r <= '0;
    end else begin
      we_r <= '0;
      if (take && !clr && !blockCfgSet) begin
        word_r  <= softIn;
        waddr_r <= fillIdx_r;
        if (phase_r == 3'd0)
          we_r[fillSel_r ? 3 : 0] <= 1'b1;
        else if (phase_r[0])
          we_r[fillSel_r ? 4 : 1] <= 1'b1;
        else
          we_r[fillSel_r ? 5 : 2] <= 1'b1;
      end
    end
  end

  // Buffer occupancy and input ready
  always_comb begin
    fullNxt = bufFull_r;
    if (lastSym)
      fullNxt[fillSel_r] = 1'b1;
    if (decEnd)
      fullNxt[decSel_r] = 1'b0;
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      bufFull_r <= '0;
      fillSel_r <= 1'b0;
      decSel_r  <= 1'b0;
      inReady_r <= 1'b0;
    end else if (clr) begin
      bufFull_r <= '0;
      fillSel_r <= 1'b0;
      decSel_r  <= 1'b0;
      inReady_r <= 1'b0;
    end else begin
      bufFull_r <= fullNxt;
      fillSel_r <= fillSel_r ^ (lastSym && `TDC_DOUBLE_BUF);
      decSel_r  <= decSel_r ^ (decEnd && `TDC_DOUBLE_BUF);
      inReady_r <= !fullNxt[fillSel_r ^ (lastSym && `TDC_DOUBLE_BUF)]
                   && !inHold_r;
    end
  end

  // Decode sequencer: issues reads for each pass
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r   <= DEC_IDLE;
      decLen_r  <= '0;
      decIter_r <= '0;
      rdIdx_r   <= '0;
      revIdx_r  <= '0;
      passCnt_r <= '0;
      rdEn_r    <= 1'b0;
      rdFin_r   <= 1'b0;
    end else if (clr) begin
      state_r <= DEC_IDLE;
      rdEn_r  <= 1'b0;
    end else begin
      case (state_r)
        DEC_IDLE: begin
          if (bufFull_r[decSel_r] && !outReady_r) begin
            state_r   <= DEC_READ;
            decLen_r  <= cfgLen_r;
            decIter_r <= (cfgIter_r == '0) ? 4'h1 : cfgIter_r;
            rdIdx_r   <= '0;
            revIdx_r  <= cfgLen_r - 1'b1;
            passCnt_r <= '0;
            rdEn_r    <= 1'b1;
            rdFin_r   <= (cfgIter_r <= 4'h1);
          end
        end
        DEC_READ: begin
          if (rdIdx_r == decLen_r - 1'b1) begin
            rdIdx_r  <= '0;
            revIdx_r <= decLen_r - 1'b1;
            if (passCnt_r == decIter_r - 1'b1) begin
              state_r <= DEC_FLUSH;
              rdEn_r  <= 1'b0;
            end else begin
              passCnt_r <= passCnt_r + 1'b1;
              rdFin_r   <= (passCnt_r == decIter_r - 4'h2);
            end
          end else begin
            rdIdx_r  <= rdIdx_r + 1'b1;
            revIdx_r <= revIdx_r - 1'b1;
          end
        end
        DEC_FLUSH: begin
          if (decEnd)
            state_r <= DEC_IDLE;
        end
        default: state_r <= DEC_IDLE;
      endcase
    end
  end

  // Read-latency tag pipeline
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pv_r <= '0;
      pf_r <= '0;
      for (int i = 0; i < LAT; i++)
        pi_r[i] <= '0;
    end else begin
      pv_r[0] <= rdEn_r;
      pf_r[0] <= rdFin_r;
      pi_r[0] <= rdIdx_r;
      for (int i = 1; i < LAT; i++) begin
        pv_r[i] <= pv_r[i-1];
        pf_r[i] <= pf_r[i-1];
        pi_r[i] <= pi_r[i-1];
      end
    end
  end

  assign retFin = pv_r[LAT-1] && pf_r[LAT-1] && state_r != DEC_IDLE;
  assign retIdx = pi_r[LAT-1];
  assign decEnd = retFin && state_r == DEC_FLUSH && retIdx == decLen_r - 1'b1;

  // Hard decision from information plus systematic parity of the held buffer
  assign llr = decSel_r
      ? {port_one_info_b[`TDC_SOFT_W-1], port_one_info_b}
        + {port_one_sys_parity_b[`TDC_SOFT_W-1], port_one_sys_parity_b}
      : {port_one_info_a[`TDC_SOFT_W-1], port_one_info_a}
        + {port_one_sys_parity_a[`TDC_SOFT_W-1], port_one_sys_parity_a};

  always_ff @(posedge ref_clk) begin
    if (retFin)
      hardMem[retIdx] <= ~llr[6];
  end

  // Output handshake
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      outReady_r <= 1'b0;
      hardOut_r  <= 1'b0;
      outIdx_r   <= '0;
      outLen_r   <= '0;
    end else if (clr) begin
      outReady_r <= 1'b0;
      outIdx_r   <= '0;
    end else if (decEnd) begin
      outReady_r <= 1'b1;
      outIdx_r   <= '0;
      outLen_r   <= decLen_r;
      hardOut_r  <= (retIdx == '0) ? ~llr[6] : hardMem[0];
    end else if (outReady_r && outAck) begin
      if (outIdx_r == outLen_r - 1'b1) begin
        outReady_r <= 1'b0;
      end else begin
        outIdx_r  <= outIdx_r + 1'b1;
        hardOut_r <= hardMem[outIdx_r + 1'b1];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b)
      blkCnt_r <= '0;
    else if (decEnd)
      blkCnt_r <= blkCnt_r + 16'h0001;
  end

  // AXI4-Lite write channel
  assign wrGo = !awRdy_r && !wRdy_r && !bValid_r;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      awRdy_r  <= 1'b1;
      wRdy_r   <= 1'b1;
      bValid_r <= 1'b0;
      bResp_r  <= `TDC_RESP_OK;
      awAddr_r <= '0;
      wData_r  <= '0;
      wStrb0_r <= 1'b0;
    end else begin
      if (s_axi_awvalid && awRdy_r) begin
        awRdy_r  <= 1'b0;
        awAddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && wRdy_r) begin
        wRdy_r   <= 1'b0;
        wData_r  <= s_axi_wdata;
        wStrb0_r <= s_axi_wstrb[0];
      end
      if (wrGo) begin
        bValid_r <= 1'b1;
        bResp_r  <= (awAddr_r == `TDC_REG_CTRL) ? `TDC_RESP_OK : `TDC_RESP_ERR;
      end
      if (bValid_r && s_axi_bready) begin
        bValid_r <= 1'b0;
        awRdy_r  <= 1'b1;
        wRdy_r   <= 1'b1;
      end
    end
  end

  // Control register: self-clearing soft clear, intake hold
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      softClr_r <= 1'b0;
      inHold_r  <= 1'b0;
    end else begin
      softClr_r <= 1'b0;
      if (wrGo && awAddr_r == `TDC_REG_CTRL && wStrb0_r) begin
        softClr_r <= wData_r[`TDC_CTRL_CLR];
        inHold_r  <= wData_r[`TDC_CTRL_HOLD];
      end
    end
  end

  // AXI4-Lite read channel
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      arRdy_r  <= 1'b1;
      rValid_r <= 1'b0;
      rResp_r  <= `TDC_RESP_OK;
      rData_r  <= '0;
    end else if (s_axi_arvalid && arRdy_r) begin
      arRdy_r  <= 1'b0;
      rValid_r <= 1'b1;
      rResp_r  <= `TDC_RESP_OK;
      case (s_axi_araddr)
        `TDC_REG_CTRL: rData_r <= {30'h0, inHold_r, 1'b0};
        `TDC_REG_STAT: rData_r <= {24'h0, 2'(state_r), bufFull_r, fillSel_r,
                                   decSel_r, outReady_r, inReady_r};
        `TDC_REG_CNT:  rData_r <= {16'h0, blkCnt_r};
        default: begin
          rData_r <= '0;
          rResp_r <= `TDC_RESP_ERR;
        end
      endcase
    end else if (rValid_r && s_axi_rready) begin
      rValid_r <= 1'b0;
      arRdy_r  <= 1'b1;
    end
  end

  assign inReady              = inReady_r;
  assign hardOut              = hardOut_r;
  assign outReady             = outReady_r;
  assign mem_write_word       = word_r;
  assign memWriteAddr         = waddr_r;
  assign {intl_parity_we_b, sys_parity_we_b, info_we_b} = we_r[5:3];
  assign {intl_parity_we_a, sys_parity_we_a, info_we_a} = we_r[2:0];
  assign port_one_read_en     = rdEn_r;
  assign port_two_read_en     = rdEn_r;
  assign port_one_info_addr   = rdIdx_r;
  assign port_one_parity_addr = rdIdx_r;
  assign port_two_info_addr   = revIdx_r;
  assign port_two_parity_addr = revIdx_r;
  assign s_axi_awready        = awRdy_r;
  assign s_axi_wready         = wRdy_r;
  assign s_axi_bvalid         = bValid_r;
  assign s_axi_bresp          = bResp_r;
  assign s_axi_arready        = arRdy_r;
  assign s_axi_rvalid         = rValid_r;
  assign s_axi_rresp          = rResp_r;
  assign s_axi_rdata          = rData_r;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  property p_passes;
    state_r == DEC_READ && rdIdx_r == decLen_r - 1'b1 && !clr
      && passCnt_r == decIter_r - 1'b1 |=> state_r == DEC_FLUSH && !rdEn_r;
  endproperty
  a_passes: assert property (p_passes) else $error("pass count wrong");

  property p_cfg;
    blockCfgSet && !clr |=> fillIdx_r == '0 && phase_r == '0 && cfgLen_r == $past(blockLen);
  endproperty
  a_cfg: assert property (p_cfg) else $error("config strobe ignored");

  property p_ignore;
    !(inValid && inReady_r) |=> we_r == '0;
  endproperty
  a_ignore: assert property (p_ignore) else $error("write without valid");

  property p_word;
    take && !clr && !blockCfgSet |=> $onehot(we_r) && word_r == $past(softIn);
  endproperty
  a_word: assert property (p_word) else $error("bad memory write");

  property p_last;
    outReady_r && outAck && !clr && outIdx_r == outLen_r - 1'b1 |=> !outReady_r;
  endproperty
  a_last: assert property (p_last) else $error("output ready stuck");

  property p_full;
    bufFull_r == 2'b11 |-> !inReady_r;
  endproperty
  a_full: assert property (p_full) else $error("ready while full");

  property p_clear;
    sync_clear |=> state_r == DEC_IDLE && !outReady_r && bufFull_r == 2'b00;
  endproperty
  a_clear: assert property (p_clear) else $error("clear did not abandon");

  property p_lat;
    rdEn_r |-> ##LAT pv_r[LAT-1];
  endproperty
  a_lat: assert property (p_lat) else $error("return tag misaligned");
endmodule
`default_nettype wire

// >>> sim/tdc_mem_model.sv
// External symbol memory model: two buffers of three streams, one-cycle read
`default_nettype none
module tdc_mem_model
  import tdc_pkg::*;
(
  // Clock
  input  wire logic                ref_clk,
  // Write side
  input  wire tdc_pkg::tdc_soft_t  mem_write_word,
  input  wire tdc_pkg::tdc_len_t   memWriteAddr,
  input  wire logic                info_we_a,
  input  wire logic                sys_parity_we_a,
  input  wire logic                intl_parity_we_a,
  input  wire logic                info_we_b,
  input  wire logic                sys_parity_we_b,
  input  wire logic                intl_parity_we_b,
  // Read side
  input  wire logic                port_one_read_en,
  input  wire logic                port_two_read_en,
  input  wire tdc_pkg::tdc_len_t   port_one_info_addr,
  input  wire tdc_pkg::tdc_len_t   port_two_info_addr,
  input  wire tdc_pkg::tdc_len_t   port_one_parity_addr,
  input  wire tdc_pkg::tdc_len_t   port_two_parity_addr,
  // Returned words
  output tdc_pkg::tdc_soft_t       port_one_info_a,
  output tdc_pkg::tdc_soft_t       port_two_info_a,
  output tdc_pkg::tdc_soft_t       port_one_sys_parity_a,
  output tdc_pkg::tdc_soft_t       port_two_sys_parity_a,
  output tdc_pkg::tdc_soft_t       port_one_intl_parity_a,
  output tdc_pkg::tdc_soft_t       port_two_intl_parity_a,
  output tdc_pkg::tdc_soft_t       port_one_info_b,
  output tdc_pkg::tdc_soft_t       port_two_info_b,
  output tdc_pkg::tdc_soft_t       port_one_sys_parity_b,
  output tdc_pkg::tdc_soft_t       port_two_sys_parity_b,
  output tdc_pkg::tdc_soft_t       port_one_intl_parity_b,
  output tdc_pkg::tdc_soft_t       port_two_intl_parity_b
);
  timeunit 1ns;
  timeprecision 1ps;
  import tdc_pkg::*;
  tdc_soft_t  mem [2][3][8192];
  tdc_soft_t  q [2][2][3];
  logic [5:0] we;
  assign we = {intl_parity_we_b, sys_parity_we_b, info_we_b,
               intl_parity_we_a, sys_parity_we_a, info_we_a};
  // Enable picks buffer and stream
  always_ff @(posedge ref_clk) begin
    for (int k = 0; k < 6; k++) begin
      if (we[k]) mem[k / 3][k % 3][memWriteAddr] <= mem_write_word;
    end
  end
  // Idle ports toggle so stale words never look valid
  always_ff @(posedge ref_clk) begin
    for (int b = 0; b < 2; b++) begin
      for (int s = 0; s < 3; s++) begin
        q[b][0][s] <= port_one_read_en ?
          mem[b][s][s == 0 ? port_one_info_addr : port_one_parity_addr] : ~q[b][0][s];
        q[b][1][s] <= port_two_read_en ?
          mem[b][s][s == 0 ? port_two_info_addr : port_two_parity_addr] : ~q[b][1][s];
      end
    end
  end
  assign port_one_info_a        = q[0][0][0];
  assign port_one_sys_parity_a  = q[0][0][1];
  assign port_one_intl_parity_a = q[0][0][2];
  assign port_two_info_a        = q[0][1][0];
  assign port_two_sys_parity_a  = q[0][1][1];
  assign port_two_intl_parity_a = q[0][1][2];
  assign port_one_info_b        = q[1][0][0];
  assign port_one_sys_parity_b  = q[1][0][1];
  assign port_one_intl_parity_b = q[1][0][2];
  assign port_two_info_b        = q[1][1][0];
  assign port_two_sys_parity_b  = q[1][1][1];
  assign port_two_intl_parity_b = q[1][1][2];
endmodule
`default_nettype wire

// >>> sim/testbench.sv
// Self-checking bench for the turbo decoder port shell
`include "tdc_cfg.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import tdc_pkg::*;
  logic ref_clk = 1'b0, rst_b = 1'b0, sync_clear = 1'b0, blockCfgSet = 1'b0;
  tdc_len_t blockLen = '0;
  tdc_iter_t iterCount = '0;
  tdc_rate_t codeRate = '0;
  tdc_soft_t softIn = '0;
  logic inValid = 1'b0, outAck = 1'b0, inReady, hardOut, outReady;
  tdc_soft_t mem_write_word;
  tdc_len_t memWriteAddr, port_one_info_addr, port_two_info_addr;
  tdc_len_t port_one_parity_addr, port_two_parity_addr;
  logic info_we_a, sys_parity_we_a, intl_parity_we_a;
  logic info_we_b, sys_parity_we_b, intl_parity_we_b, port_one_read_en, port_two_read_en;
  tdc_soft_t port_one_info_a, port_two_info_a, port_one_sys_parity_a, port_two_sys_parity_a;
  tdc_soft_t port_one_intl_parity_a, port_two_intl_parity_a, port_one_info_b;
  tdc_soft_t port_two_info_b, port_one_sys_parity_b, port_two_sys_parity_b;
  tdc_soft_t port_one_intl_parity_b, port_two_intl_parity_b;
  logic [3:0] s_axi_awaddr = '0, s_axi_araddr = '0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int miscompares = 0;
  int nChecks = 0;

  tdc_top dut_u (.*);
  tdc_mem_model mem_u (.*);

  always #25 ref_clk = ~ref_clk;

  function automatic int sv(input int i, input int m, input int k);
    return (i * k) % m - m / 2;
  endfunction

  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    nChecks++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic report_and_stop;
    if (miscompares == 0 && nChecks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic cfg(input int len, input int it, input int rt);
    @(posedge ref_clk);
    blockLen <= tdc_len_t'(len);
    iterCount <= tdc_iter_t'(it);
    codeRate <= tdc_rate_t'(rt);
    blockCfgSet <= 1'b1;
    @(posedge ref_clk);
    blockCfgSet <= 1'b0;
  endtask

  // Holds the symbol until an edge sees input ready high
  task automatic send_sym(input int v);
    softIn <= tdc_soft_t'(v);
    inValid <= 1'b1;
    do @(posedge ref_clk); while (inReady !== 1'b1);
  endtask

  task automatic send_block(input int len, input int rt);
    @(posedge ref_clk);
    for (int i = 0; i < len; i++) begin
      send_sym(sv(i, 13, 5));
      send_sym(sv(i, 11, 3));
      if (rt == 0) send_sym(i);
    end
    inValid <= 1'b0;
  endtask

  task automatic t_decode(input int len, input int it, input int rt, input int blocks);
    logic [31:0] d;
    logic [1:0] r;
    int n;
    cfg(len, it, rt);
    send_block(len, rt);
    n = 0;
    for (int k = 0; k < 20000 && outReady !== 1'b1; k++) begin
      @(negedge ref_clk);
      if (port_one_read_en === 1'b1 && port_two_read_en === 1'b1) n++;
    end
    check("read cycles", 32'(it * len), 32'(n));
    @(posedge ref_clk);
    outAck <= 1'b1;
    for (int i = 0; i < len; i++) begin
      @(negedge ref_clk);
      check("hardOut", 32'(sv(i, 13, 5) + sv(i, 11, 3) >= 0), 32'(hardOut));
      @(posedge ref_clk);
    end
    outAck <= 1'b0;
    @(negedge ref_clk);
    check("outReady", 32'h0, 32'(outReady));
    if (rt == 0)
      check("intl", 32'(tdc_soft_t'(len - 1)), 32'(mem_u.mem[1][2][len - 1]));
    axi_rd(`TDC_REG_CNT, d, r);
    check("count", 32'(blocks), d);
  endtask

  task automatic t_regs;
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(`TDC_REG_STAT, d, r);
    check("status", 32'h1, d);
    axi_wr(`TDC_REG_CTRL, 32'h2, r);
    check("bresp", 32'(`TDC_RESP_OK), 32'(r));
    repeat (2) @(negedge ref_clk);
    check("inReady held", 32'h0, 32'(inReady));
    axi_rd(`TDC_REG_CTRL, d, r);
    check("ctrl", 32'h2, d);
    axi_wr(`TDC_REG_CTRL, 32'h0, r);
    axi_wr(`TDC_REG_STAT, 32'h1, r);
    check("bresp ro", 32'(`TDC_RESP_ERR), 32'(r));
    axi_rd(4'hc, d, r);
    check("rresp", 32'(`TDC_RESP_ERR), 32'(r));
    check("rdata", 32'h0, d);
    repeat (2) @(negedge ref_clk);
    check("inReady free", 32'h1, 32'(inReady));
  endtask

  task automatic t_full_clear;
    logic [31:0] d;
    logic [1:0] r;
    cfg(40, 15, 1);
    send_block(40, 1);
    send_block(40, 1);
    @(negedge ref_clk);
    check("inReady full", 32'h0, 32'(inReady));
    check("addr pair", 32'd39, 32'(port_one_info_addr) + 32'(port_two_info_addr));
    check("par pair", 32'd39, 32'(port_one_parity_addr) + 32'(port_two_parity_addr));
    @(posedge ref_clk);
    inValid <= 1'b1;
    softIn <= 6'h15;
    repeat (4) begin
      @(negedge ref_clk);
      check("we", 32'h0, 32'({info_we_a, info_we_b, sys_parity_we_a, sys_parity_we_b}));
    end
    @(posedge ref_clk);
    inValid <= 1'b0;
    sync_clear <= 1'b1;
    @(posedge ref_clk);
    sync_clear <= 1'b0;
    @(negedge ref_clk);
    check("clr ready", 32'h0, 32'({inReady, outReady, port_one_read_en}));
    @(negedge ref_clk);
    check("clr inReady", 32'h1, 32'(inReady));
    axi_rd(`TDC_REG_STAT, d, r);
    check("status clr", 32'h1, d & 32'hf3);
    send_block(40, 1);
    axi_wr(`TDC_REG_CTRL, 32'h1, r);
    @(negedge ref_clk);
    check("soft clr", 32'h0, 32'({inReady, port_one_read_en, outReady}));
  endtask

  task automatic t_reset;
    @(negedge ref_clk);
    check("inReady rel", 32'h0, 32'(inReady));
    @(negedge ref_clk);
    check("inReady rst", 32'h1, 32'(inReady));
    check("outReady rst", 32'h0, 32'(outReady));
  endtask

  initial begin
    repeat (16) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_reset();
    t_regs();
    t_decode(40, 2, 1, 1);
    t_decode(41, 1, 0, 2);
    t_full_clear();
    report_and_stop();
  end

  initial begin
    repeat (40000) @(posedge ref_clk);
    miscompares++;
    report_and_stop();
  end
endmodule
`default_nettype wire
